/* common/vfd_regs.vh */
// Register map, field positions, reset values and timing counts of the display scan controller
`ifndef VFD_REGS_VH
`define VFD_REGS_VH

// ----------------------------------------
// Register offsets (low byte of the SFR address)
// ----------------------------------------
`define VFD_OFS_CONFIG_PRIMARY 8'hA0
`define VFD_OFS_TIMING_CONFIG 8'hA1
`define VFD_OFS_MASK_COUNT 8'hA2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define VFD_RST_CONFIG_PRIMARY 8'h00
`define VFD_RST_TIMING_CONFIG 8'h00
`define VFD_RST_MASK_COUNT 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define VFD_KSF_BIT 7
`define VFD_NOISE_MODE_BIT 6
`define VFD_DIGIT_SRC_BIT 5
`define VFD_SEG_COUNT_MSB 4
`define VFD_SEG_COUNT_LSB 0
`define VFD_DIGIT_COUNT_MSB 7
`define VFD_DIGIT_COUNT_LSB 4
`define VFD_CUT_WIDTH_MSB 3
`define VFD_CUT_WIDTH_LSB 1
`define VFD_SLOT_LONG_BIT 0
`define VFD_DIGIT_STOP 4'h0

// ----------------------------------------
// Geometry and timing counts (main oscillator periods)
// ----------------------------------------
`define VFD_PIN_COUNT 53
`define VFD_DEDICATED_COUNT 13
`define VFD_SHARED_COUNT 40
`define VFD_SEG_MIN 9
`define VFD_RECORD_BYTES 7
`define VFD_SLOT_SHORT 1024
`define VFD_SLOT_LONG 2048

`endif

/* rtl/vfd_slot_timer.v */
// Slot timer: cycle count inside a slot and slot index inside a frame
`timescale 1ns/100ps
`default_nettype none
`include "vfd_regs.vh"

module vfd_slot_timer #(
  parameter CW = 12
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire run_i,
  input wire long_slot_i,
  input wire [4:0] last_slot_i,
  output reg [CW-1:0] slot_cnt_o,
  output reg [4:0] slot_idx_o,
  output wire slot_start_o
);

  localparam [CW-1:0] LAST_LONG = `VFD_SLOT_LONG - 1;
  localparam [CW-1:0] LAST_SHORT = `VFD_SLOT_SHORT - 1;

  wire [CW-1:0] slot_last;

  assign slot_last = long_slot_i ? LAST_LONG : LAST_SHORT;
  assign slot_start_o = run_i & (slot_cnt_o == {CW{1'b0}});

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_cnt_o <= {CW{1'b0}};
      slot_idx_o <= 5'h00;
    end else if (!run_i) begin
      slot_cnt_o <= {CW{1'b0}};
      slot_idx_o <= 5'h00;
    end else if (slot_cnt_o >= slot_last) begin
      slot_cnt_o <= {CW{1'b0}};
      // Digits ascending, then the key-scan slot, then wrap
      if (slot_idx_o >= last_slot_i) begin
        slot_idx_o <= 5'h00;
      end else begin
        slot_idx_o <= slot_idx_o + 5'h01;
      end
    end else begin
      slot_cnt_o <= slot_cnt_o + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

/* rtl/vfd_scan_controller.v */
// Display scan controller: registers, display data fetch, pin drive
`timescale 1ns/100ps
`default_nettype none
`include "vfd_regs.vh"


module vfd_scan_controller #(
  parameter CW = 12
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  output reg [7:0] sfr_rdata_o,
  output reg [6:0] ram_addr_o,
  output reg ram_rd_o,
  input wire [7:0] ram_data_i,
  input wire [39:0] port_latch_i,
  output reg [52:0] disp_out_o,
  output reg [39:0] port_role_o,
  output reg key_scan_interrupt_o,
  output reg key_scan_phase_flag_o,
  output reg noise_mode_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Fraction of a slot in steps of 1/64
  function [CW-1:0] slot_part;
    input [CW-1:0] len;
    input [6:0] steps;
    reg [CW+6:0] prod;
    begin
      prod = len * steps;
      slot_part = prod[CW+5:6];
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [6:0] display_config_primary;
  reg [7:0] display_timing_config;
  reg [7:0] display_mask_count;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      display_config_primary <= 7'h00;
      display_timing_config <= `VFD_RST_TIMING_CONFIG;
      display_mask_count <= `VFD_RST_MASK_COUNT;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        `VFD_OFS_CONFIG_PRIMARY: begin
          display_config_primary <= sfr_wdata_i[6:0];
        end
        `VFD_OFS_TIMING_CONFIG: begin
          display_timing_config <= sfr_wdata_i;
        end
        `VFD_OFS_MASK_COUNT: begin
          display_mask_count <= sfr_wdata_i;
        end
        default: begin
          display_timing_config <= display_timing_config;
        end
      endcase
    end
  end

  wire [3:0] digit_count_field;
  wire [2:0] segment_cut_width;
  wire digit_source_select;
  wire running;
  wire [4:0] digit_total;
  wire [5:0] seg_total;

  assign digit_count_field = display_timing_config[`VFD_DIGIT_COUNT_MSB:`VFD_DIGIT_COUNT_LSB];
  assign segment_cut_width = display_timing_config[`VFD_CUT_WIDTH_MSB:`VFD_CUT_WIDTH_LSB];
  assign digit_source_select = display_config_primary[`VFD_DIGIT_SRC_BIT];
  assign running = (digit_count_field != `VFD_DIGIT_STOP);
  assign digit_total = {1'b0, digit_count_field} + 5'h01;
  assign seg_total = {1'b0, display_config_primary[4:0]} + 6'd`VFD_SEG_MIN;

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  reg [7:0] next_rdata;

  always @* begin
    case (sfr_addr_i)
      `VFD_OFS_CONFIG_PRIMARY: next_rdata = {key_scan_phase_flag_o, display_config_primary};
      `VFD_OFS_TIMING_CONFIG: next_rdata = display_timing_config;
      `VFD_OFS_MASK_COUNT: next_rdata = display_mask_count;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // Slot timing
  // ----------------------------------------
  wire [CW-1:0] slot_cnt;
  wire [4:0] slot_idx;
  wire slot_start;

  vfd_slot_timer #(
    .CW(CW)
  ) u_timer (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .run_i(running),
    .long_slot_i(display_timing_config[`VFD_SLOT_LONG_BIT]),
    .last_slot_i(digit_total),
    .slot_cnt_o(slot_cnt),
    .slot_idx_o(slot_idx),
    .slot_start_o(slot_start)
  );

  wire [CW-1:0] slot_len;
  wire [CW-1:0] lead;
  wire [CW-1:0] dig_end;
  wire [CW-1:0] seg_cut;
  wire key_slot;
  wire dig_on;
  wire seg_on;

  localparam [CW-1:0] LEN_LONG = `VFD_SLOT_LONG;
  localparam [CW-1:0] LEN_SHORT = `VFD_SLOT_SHORT;

  assign slot_len = display_timing_config[`VFD_SLOT_LONG_BIT] ? LEN_LONG : LEN_SHORT;
  assign key_slot = running & (slot_idx == digit_total);
  // Digit window opens after the fetch has finished
  assign lead = slot_part(slot_len, 7'd2);
  // Eight digit widths, one per brightness step
  assign dig_end = slot_len - slot_part(slot_len, {1'b0, segment_cut_width, 3'b000}) - lead;
  assign seg_cut = slot_part(slot_len, {4'h0, segment_cut_width});
  assign dig_on = (slot_cnt >= lead) && (slot_cnt < dig_end);
  assign seg_on = (slot_cnt >= lead + seg_cut) && (slot_cnt + seg_cut < dig_end);

  // ----------------------------------------
  // Display data fetch
  // ----------------------------------------
  reg [2:0] req_byte;
  reg [2:0] rx_byte;
  reg rx_valid;
  reg [55:0] pend;
  reg [52:0] active;
  integer j;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ram_rd_o <= 1'b0;
      ram_addr_o <= 7'h00;
      req_byte <= 3'h0;
      rx_byte <= 3'h0;
      rx_valid <= 1'b0;
      pend <= 56'h0;
    end else begin
      rx_valid <= ram_rd_o;
      rx_byte <= req_byte;
      if (slot_start && !key_slot) begin
        ram_rd_o <= 1'b1;
        ram_addr_o <= slot_idx[3:0] * 7'd`VFD_RECORD_BYTES;
        req_byte <= 3'h0;
      end else if (ram_rd_o) begin
        if (req_byte == 3'd6) begin
          ram_rd_o <= 1'b0;
        end else begin
          req_byte <= req_byte + 3'h1;
          ram_addr_o <= ram_addr_o + 7'h01;
        end
      end
      if (rx_valid) begin
        pend[rx_byte*8 +: 8] <= ram_data_i;
      end
    end
  end

  // Latched into the output pattern when the window opens
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active <= 53'h0;
    end else if (running && !key_slot && slot_cnt == lead) begin
      for (j = 0; j < `VFD_PIN_COUNT; j = j + 1) begin
        // Masked leading bits are only refreshed in the first slot
        if (!(digit_source_select && j < display_mask_count && slot_idx != 5'h00)) begin
          active[j] <= pend[j];
        end
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  reg [52:0] next_disp;
  reg [39:0] next_role;
  integer i;

  always @* begin
    next_disp = 53'h0;
    next_role = 40'h0;
    for (i = 0; i < `VFD_PIN_COUNT; i = i + 1) begin
      if (!running) begin
        if (i >= `VFD_DEDICATED_COUNT) begin
          next_role[i-13] = 1'b1;
          next_disp[i] = port_latch_i[i-13];
        end
      end else if (!digit_source_select && i >= `VFD_PIN_COUNT - digit_total) begin
        // Digits sit at the top pins and win over segments
        next_disp[i] = !key_slot && dig_on && (52 - i == slot_idx);
      end else if (i < seg_total) begin
        if (key_slot) begin
          next_disp[i] = port_latch_i[i];
        end else if (digit_source_select) begin
          next_disp[i] = active[i] & dig_on;
        end else begin
          next_disp[i] = active[i] & seg_on;
        end
      end else if (i >= `VFD_DEDICATED_COUNT) begin
        next_role[i-13] = 1'b1;
        next_disp[i] = port_latch_i[i-13];
      end
      // Pins 0..12 have no port role and stay low when unused
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      disp_out_o <= 53'h0;
      port_role_o <= 40'h0;
      key_scan_interrupt_o <= 1'b0;
      key_scan_phase_flag_o <= 1'b0;
      noise_mode_o <= 1'b0;
    end else begin
      disp_out_o <= next_disp;
      port_role_o <= next_role;
      key_scan_interrupt_o <= slot_start & key_slot;
      key_scan_phase_flag_o <= key_slot;
      noise_mode_o <= display_config_primary[`VFD_NOISE_MODE_BIT];
    end
  end

endmodule
`default_nettype wire

/* test/vfd_ram_model.sv */
// Display RAM model answering the controller's fetch requests
`timescale 1ns/100ps
`default_nettype none
module vfd_ram_model (
  input wire logic clk_sys_i,
  input wire logic [6:0] ram_addr_i,
  input wire logic ram_rd_i,
  output logic [7:0] ram_data_o
);
  logic [7:0] mem [0:127];
  initial begin
    ram_data_o = 8'h00;
  end
  // Outside a request the bus shows a changing pattern
  always @(posedge clk_sys_i) begin
    ram_data_o <= ram_rd_i ? mem[ram_addr_i] : ~ram_data_o;
  end
endmodule
`default_nettype wire

/* test/vfd_scan_controller_sva.sv */
// Port checks of the display scan controller
`timescale 1ns/100ps
`default_nettype none
module vfd_scan_controller_sva #(
  parameter CW = 12
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [6:0] ram_addr_o,
  input wire logic ram_rd_o,
  input wire logic [39:0] port_latch_i,
  input wire logic [52:0] disp_out_o,
  input wire logic [39:0] port_role_o,
  input wire logic key_scan_interrupt_o,
  input wire logic key_scan_phase_flag_o
);
  logic [15:0] gap;
  logic [15:0] hi;
  logic seen;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // A write to the timing register forgets the frame history
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap <= 16'h0000;
      hi <= 16'h0000;
      seen <= 1'b0;
    end else begin
      gap <= key_scan_interrupt_o ? 16'h0001 : gap + 16'h0001;
      hi <= key_scan_phase_flag_o ? hi + 16'h0001 : 16'h0000;
      if (sfr_wr_i && sfr_addr_i == 8'hA1) seen <= 1'b0;
      else if (key_scan_interrupt_o) seen <= 1'b1;
    end
  end
  sequence seven_reads;
    ram_rd_o [*7] ##1 !ram_rd_o;
  endsequence
  irq_pulse_a: assert property (key_scan_interrupt_o |=> !key_scan_interrupt_o)
    else $error("interrupt too wide");
  irq_flag_a: assert property (key_scan_interrupt_o |-> ##[0:1] key_scan_phase_flag_o)
    else $error("interrupt without key flag");
  slot_len_a: assert property ($fell(key_scan_phase_flag_o) && seen |-> hi == 16'h0400 || hi == 16'h0800)
    else $error("key slot length");
  frame_gap_a: assert property (key_scan_interrupt_o && seen |->
    gap[9:0] == 10'h000 && gap >= 16'h0C00 && gap <= 16'h8800)
    else $error("frame length");
  no_fetch_a: assert property (seen && key_scan_phase_flag_o && $past(key_scan_phase_flag_o) |-> !ram_rd_o)
    else $error("fetch in key slot");
  fetch_burst_a: assert property ($rose(ram_rd_o) |-> seven_reads)
    else $error("fetch burst length");
  addr_step_a: assert property (ram_rd_o && $past(ram_rd_o) |-> ram_addr_o == $past(ram_addr_o) + 7'h01)
    else $error("fetch address step");
  addr_base_a: assert property ($rose(ram_rd_o) |-> ram_addr_o % 7 == 0)
    else $error("fetch base address");
  port_mirror_a: assert property (((disp_out_o[52:13] ^ $past(port_latch_i)) & port_role_o) == 40'h0)
    else $error("port pin not mirroring latch");
  unmapped_rd_a: assert property (sfr_rd_i && (sfr_addr_i < 8'hA0 || sfr_addr_i > 8'hA2) |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  flag_read_a: assert property (sfr_rd_i && sfr_addr_i == 8'hA0 |=> sfr_rdata_o[7] == $past(key_scan_phase_flag_o))
    else $error("flag bit read");
endmodule
bind vfd_scan_controller vfd_scan_controller_sva #(.CW(CW)) i_sva (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
  .ram_addr_o(ram_addr_o), .ram_rd_o(ram_rd_o), .port_latch_i(port_latch_i), .disp_out_o(disp_out_o),
  .port_role_o(port_role_o), .key_scan_interrupt_o(key_scan_interrupt_o),
  .key_scan_phase_flag_o(key_scan_phase_flag_o));
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench of the display scan controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [39:0] latch = 40'h0;
  logic [7:0] rdata, ram_data, d, v;
  logic [6:0] ram_addr;
  logic ram_rd, irq, key_scan_phase_flag, noise, mode2;
  logic [52:0] pins;
  logic [39:0] role, er;
  logic [15:0] cfgs [0:4];
  int n_fail = 0;
  int checked = 0;
  int cnt, s, dd, len, cut, w;
  // ----------------------------------------
  // Clock, design and RAM
  // ----------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  vfd_scan_controller i_dut (.clk_sys_i(clk), .reset_n_i(reset_n), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .ram_addr_o(ram_addr), .ram_rd_o(ram_rd),
    .ram_data_i(ram_data), .port_latch_i(latch), .disp_out_o(pins), .port_role_o(role),
    .key_scan_interrupt_o(irq), .key_scan_phase_flag_o(key_scan_phase_flag), .noise_mode_o(noise));
  vfd_ram_model i_ram (.clk_sys_i(clk), .ram_addr_i(ram_addr), .ram_rd_i(ram_rd), .ram_data_o(ram_data));
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic chk(input logic [52:0] seen, input logic [52:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    x = rdata;
  endtask
  task automatic wait_irq;
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (irq !== 1'b1 && cnt < 40000);
  endtask
  function automatic logic [52:0] exp_pins(input logic key);
    for (int i = 0; i < 53; i++) begin
      if (i >= 53 - dd) exp_pins[i] = (i == 52) && !key;
      else if (i < s) exp_pins[i] = key ? latch[i] : i_ram.mem[i / 8][i % 8];
      else if (i >= 13) exp_pins[i] = latch[i - 13];
      else exp_pins[i] = 1'b0;
    end
  endfunction
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #950000;
    n_fail++;
    final_report();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(36315));
    cfgs = '{16'h0010, 16'h0017, 16'h001E, 16'h1FD0, 16'h2310};
    for (int i = 0; i < 128; i++) i_ram.mem[i] = 8'($urandom);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(role, 40'hFF_FFFF_FFFF);
    chk(pins[12:0], 13'h0000);
    for (int a = 0; a < 4; a++) begin
      rd_reg(8'(8'hA0 + a), d);
      chk(d, 8'h00);
    end
    v = 8'($urandom) | 8'h80;
    wr_reg(8'hA0, v);
    rd_reg(8'hA0, d);
    chk(d, {1'b0, v[6:0]});
    chk(noise, v[6]);
    @(posedge clk);
    latch <= {8'($urandom), 32'($urandom)};
    repeat (2) @(posedge clk);
    #1;
    chk(pins[52:13], latch);
    @(posedge clk);
    latch <= 40'h0;
    foreach (cfgs[n]) begin
      wr_reg(8'hA0, cfgs[n][15:8]);
      wr_reg(8'hA1, cfgs[n][7:0]);
      s = cfgs[n][12:8] + 9;
      mode2 = cfgs[n][13];
      dd = mode2 ? 0 : cfgs[n][7:4] + 1;
      len = cfgs[n][0] ? 2048 : 1024;
      cut = cfgs[n][3:1];
      for (int k = 0; k < 40; k++) er[k] = (k + 13 >= s) && (k + 13 < 53 - dd);
      wait_irq();
      wait_irq();
      chk(cnt, len * (cfgs[n][7:4] + 2));
      @(posedge clk);
      latch <= {8'($urandom), 32'($urandom)};
      repeat (len / 2) @(posedge clk);
      #1;
      if (!mode2) chk(pins, exp_pins(1'b1));
      rd_reg(8'hA0, d);
      chk(d, {1'b1, cfgs[n][14:8]});
      repeat (len / 2 - 3) @(posedge clk);
      w = 0;
      for (int k = 0; k < len; k++) begin
        @(posedge clk);
        #1;
        w += (pins[52] === 1'b1);
        if (k == len / 2 && cut < 7) chk(pins, exp_pins(1'b0));
        if (k == len / 2) chk(role, er);
      end
      if (!mode2) chk(w, len - len * cut / 8 - len / 16);
    end
    wait_irq();
    @(posedge clk);
    latch <= 40'h0;
    wr_reg(8'hA1, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk(role, 40'hFF_FFFF_FFFF);
    final_report();
  end
endmodule
`default_nettype wire
